/* File: inc/irq_latch_pkg.sv */
// constants for the interrupt latch and enable unit
//------------------------------------------------------------
// Function
//------------------------------------------------------------
package irq_latch_pkg;
  localparam int          NUM_SRC        = 16;
  localparam logic [7:0]  ADDR_EN_LO     = 8'h3A;
  localparam logic [7:0]  ADDR_EN_HI     = 8'h3B;
  localparam logic [7:0]  ADDR_PEND_LO   = 8'h3C;
  localparam logic [7:0]  ADDR_PEND_HI   = 8'h3D;
  localparam int          BIT_MASTER     = 0;
  localparam int          BIT_TRAP       = 2;
  localparam int          BIT_WDOG       = 3;
  localparam int          FIRST_MASKABLE = 4;
  localparam logic [15:0] PEND_IMPL      = 16'hFFFC;
  localparam logic [15:0] EN_IMPL        = 16'hFFF0;
  localparam logic [15:0] NMI_MASK       = 16'h000C;
  localparam logic [15:0] RESET_WORD     = 16'h0000;
  localparam logic [3:0]  NO_SRC         = 4'h0;
endpackage

/* File: inc/irq_req_if.sv */
// request/acceptance group between the latch unit and its arbiter
`timescale 1ns/100ps
`default_nettype none
interface irq_req_if;
  logic [15:0] pend;    // pending latches
  logic [15:0] enMask;  // combined enables per source
  logic        request; // some source acceptable
  logic [3:0]  srcIdx;  // chosen source number
  modport unit (output pend, output enMask, input request, input srcIdx);
  modport arb  (input pend, input enMask, output request, output srcIdx);
endinterface
`default_nettype wire

/* File: rtl/irq_pick.sv */
// fixed priority picker: lowest numbered acceptable source wins
`timescale 1ns/100ps
`default_nettype none
module irq_pick (
  irq_req_if.arb bus
);
  //------------------------------------------------------------
  // selection
  //------------------------------------------------------------
  wire [15:0] ready = bus.pend & bus.enMask;

  // scan from the top so the lowest index is kept last
  always_comb begin
    bus.srcIdx = irq_latch_pkg::NO_SRC;
    for (int i = irq_latch_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (ready[i]) begin
        bus.srcIdx = 4'(i);
      end
    end
  end

  assign bus.request = |ready;
endmodule // irq_pick
`default_nettype wire

/* File: rtl/interrupt_latch_enable_unit.sv */
// pending latches, enable register and master flag for the cpu core
`timescale 1ns/100ps
`default_nettype none
module interrupt_latch_enable_unit #(
  parameter int NUM_SRC = irq_latch_pkg::NUM_SRC
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [15:0] srcReq,      // one-cycle source request pulses
  input  wire logic [7:0]  sfrAddr,
  input  wire logic        sfrWr,
  input  wire logic        sfrRd,
  input  wire logic [7:0]  sfrWdata,
  input  wire logic        accept,      // cpu takes irqSrc
  input  wire logic        retInstr,    // either return instruction
  input  wire logic        retImf,      // master flag popped from stack
  input  wire logic        eiInstr,
  input  wire logic        diInstr,
  output logic      [7:0]  sfrRdata,
  output logic             irqReq,
  output logic      [3:0]  irqSrc,
  output logic             savedImf     // master flag to push
);
  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  logic [15:0] pend_ff;
  logic [15:0] en_ff;
  logic [7:0]  sfrRdata_ff;
  logic        irqReq_ff;
  logic [3:0]  irqSrc_ff;
  logic        savedImf_ff;

  irq_req_if link ();

  irq_pick u_pick (
    .bus (link)
  );

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  // one address compare, shared by write decode and read select
  function automatic logic hitAddr(input logic [7:0] a,
                                   input logic [7:0] want);
    return a == want;
  endfunction

  //------------------------------------------------------------
  // decode
  //------------------------------------------------------------
  // address hits, used by both the stores and the read select
  wire hitEnLo   = hitAddr(sfrAddr, irq_latch_pkg::ADDR_EN_LO);
  wire hitEnHi   = hitAddr(sfrAddr, irq_latch_pkg::ADDR_EN_HI);
  wire hitPendLo = hitAddr(sfrAddr, irq_latch_pkg::ADDR_PEND_LO);
  wire hitPendHi = hitAddr(sfrAddr, irq_latch_pkg::ADDR_PEND_HI);

  // store strobes per byte
  wire wrEnLo   = sfrWr && hitEnLo;
  wire wrEnHi   = sfrWr && hitEnHi;
  wire wrPendLo = sfrWr && hitPendLo;
  wire wrPendHi = sfrWr && hitPendHi;

  // zero bits of a store clear; ones keep the latch untouched
  wire [15:0] wrClr = ~{wrPendHi ? sfrWdata : 8'hFF,
                        wrPendLo ? sfrWdata : 8'hFF};
  wire [15:0] accClr = accept ? (16'h0001 << irqSrc_ff) : 16'h0000;
  wire [15:0] setReq = srcReq & irq_latch_pkg::PEND_IMPL;

  // a request in the clearing cycle wins over the clear
  wire [15:0] nxt_pend = ((pend_ff & ~wrClr & ~accClr) | setReq)
                         & irq_latch_pkg::PEND_IMPL;

  wire        master_enable_flag = en_ff[irq_latch_pkg::BIT_MASTER];
  wire [15:0] nxt_enWr = {wrEnHi ? sfrWdata : en_ff[15:8],
                          wrEnLo ? sfrWdata : en_ff[7:0]};
  wire [15:0] enImpl = nxt_enWr & (irq_latch_pkg::EN_IMPL | 16'h0001);
  // acceptance clears, return restores, then instructions and stores
  wire nxt_imf = accept   ? 1'b0 :
                 retInstr ? retImf :
                 eiInstr  ? 1'b1 :
                 diInstr  ? 1'b0 :
                 enImpl[irq_latch_pkg::BIT_MASTER];
  wire [15:0] nxt_en = {enImpl[15:1], nxt_imf};

  // maskable needs master and own flag; nonmaskable always passes
  wire [15:0] maskOpen =
    {16{master_enable_flag}} & en_ff & irq_latch_pkg::EN_IMPL;
  assign link.enMask = irq_latch_pkg::NMI_MASK | maskOpen;
  assign link.pend = pend_ff;

  wire [7:0] nxt_rdata =
    hitEnLo   ? en_ff[7:0]    :
    hitEnHi   ? en_ff[15:8]   :
    hitPendLo ? pend_ff[7:0]  :
    hitPendHi ? pend_ff[15:8] : 8'h00;

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  // latches and enables, zero after reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pend_ff <= irq_latch_pkg::RESET_WORD;
      en_ff   <= irq_latch_pkg::RESET_WORD;
    end else begin
      pend_ff <= nxt_pend;
      en_ff   <= nxt_en;
    end
  end

  // outputs toward the cpu, one flop each
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sfrRdata_ff <= 8'h00;
      irqReq_ff   <= 1'b0;
      irqSrc_ff   <= irq_latch_pkg::NO_SRC;
      savedImf_ff <= 1'b0;
    end else begin
      sfrRdata_ff <= sfrRd ? nxt_rdata : 8'h00;
      irqReq_ff   <= link.request && !accept;
      irqSrc_ff   <= link.srcIdx;
      savedImf_ff <= master_enable_flag;
    end
  end

  assign sfrRdata = sfrRdata_ff;
  assign irqReq   = irqReq_ff;
  assign irqSrc   = irqSrc_ff;
  assign savedImf = savedImf_ff;

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  // acceptance cycle followed by the cycle that shows its effects
  sequence s_accept;
    accept ##1 1'b1;
  endsequence

  // return instruction with no acceptance, then the reloaded flag
  sequence s_return;
    retInstr && !accept ##1 1'b1;
  endsequence

  // enable instruction that nothing stronger overrides
  sequence s_enable;
    eiInstr && !accept && !retInstr ##1 1'b1;
  endsequence

  // disable instruction that nothing stronger overrides
  sequence s_disable;
    diInstr && !accept && !retInstr && !eiInstr ##1 1'b1;
  endsequence

  // reset empties latches and enables
  a_reset_clear: assert property (@(posedge clk_sys)
    !resetn |=> pend_ff == 16'h0000 && en_ff == 16'h0000)
    else $error("reset left state set");

  // reset silences the outputs toward the cpu
  a_reset_quiet: assert property (@(posedge clk_sys)
    !resetn |=> !irqReq && sfrRdata == 8'h00)
    else $error("outputs active in reset");

  // every requested implemented source is latched
  a_req_sets: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    (srcReq & irq_latch_pkg::PEND_IMPL) != 16'h0000 |=>
    (pend_ff & $past(srcReq & irq_latch_pkg::PEND_IMPL)) ==
    $past(srcReq & irq_latch_pkg::PEND_IMPL))
    else $error("request did not set latch");

  // software and undefined sources hold no latch
  a_no_sw_latch: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    pend_ff[1:0] == 2'b00)
    else $error("unimplemented latch set");

  // unused enable bits stay clear
  a_en_unused: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    en_ff[3:1] == 3'b000)
    else $error("unimplemented enable bit set");

  // accepted source latch drops unless a new request meets it
  a_acc_clear: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    accept && !srcReq[irqSrc_ff] |=> !pend_ff[$past(irqSrc_ff)])
    else $error("accepted latch not cleared");

  // no latch rises without its own request
  a_wr_one_keep: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    wrPendLo || wrPendHi |=>
    (pend_ff & ~$past(pend_ff) & ~$past(srcReq)) == 16'h0000)
    else $error("write set a latch");

  // zero bits of a low byte store clear their latches
  a_clr_lo: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    wrPendLo |=>
    (pend_ff[7:0] & ~$past(sfrWdata) & ~$past(srcReq[7:0])) == 8'h00)
    else $error("low latch not cleared by store");

  // zero bits of a high byte store clear their latches
  a_clr_hi: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    wrPendHi |=>
    (pend_ff[15:8] & ~$past(sfrWdata) & ~$past(srcReq[15:8])) == 8'h00)
    else $error("high latch not cleared by store");

  // low latch byte reads back as held
  a_rd_pend_lo: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    sfrRd && hitPendLo |=> sfrRdata == $past(pend_ff[7:0]))
    else $error("low latch read wrong");

  // high latch byte reads back as held
  a_rd_pend_hi: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    sfrRd && hitPendHi |=> sfrRdata == $past(pend_ff[15:8]))
    else $error("high latch read wrong");

  // low enable byte reads back as held
  a_rd_en_lo: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    sfrRd && hitEnLo |=> sfrRdata == $past(en_ff[7:0]))
    else $error("low enable read wrong");

  // high enable byte reads back as held
  a_rd_en_hi: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    sfrRd && hitEnHi |=> sfrRdata == $past(en_ff[15:8]))
    else $error("high enable read wrong");

  // read data stays zero when nothing is read
  a_rd_idle: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    !sfrRd |=> sfrRdata == 8'h00)
    else $error("read data without read");

  // high enable store lands whole
  a_wr_en_hi: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    wrEnHi |=> en_ff[15:8] == $past(sfrWdata))
    else $error("high enable store lost");

  // low enable store lands on implemented bits
  a_wr_en_lo: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    wrEnLo && !accept && !retInstr && !eiInstr && !diInstr |=>
    en_ff[7:0] == ($past(sfrWdata) & 8'hF1))
    else $error("low enable store lost");

  // acceptance saves the flag then clears it
  a_imf_acc: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    s_accept |-> !en_ff[0] && savedImf == $past(master_enable_flag))
    else $error("master flag not saved and cleared");

  // return reloads the popped flag
  a_ret_load: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    s_return |-> en_ff[0] == $past(retImf))
    else $error("return did not restore master flag");

  // enable instruction sets the master flag
  a_ei_sets: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    s_enable |-> en_ff[0])
    else $error("enable instruction ignored");

  // disable instruction clears the master flag
  a_di_clears: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    s_disable |-> !en_ff[0])
    else $error("disable instruction ignored");

  // master flag low blocks every maskable request
  a_mask_block: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    !master_enable_flag && (pend_ff & irq_latch_pkg::NMI_MASK) == 16'h0000 && !accept
    |=> !irqReq)
    else $error("maskable request with master flag low");

  // a maskable latch passes only with its own flag set too
  a_gate_both: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    !accept && (pend_ff & irq_latch_pkg::NMI_MASK) == 16'h0000 &&
    (pend_ff & en_ff & irq_latch_pkg::EN_IMPL) == 16'h0000
    |=> !irqReq)
    else $error("request without own enable");

  // the watchdog nonmaskable latch (bit 3) is offered whatever the enables
  a_nmi_pass: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    pend_ff[3] && !accept |=> irqReq)
    else $error("nonmaskable request blocked");

  // an offered source always owns a latch
  a_src_legal: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    irqReq |-> irqSrc != 4'h0 && irqSrc != 4'h1)
    else $error("offered source without latch");

  // the offer drops right after acceptance
  a_req_drop: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    accept |=> !irqReq)
    else $error("request held after acceptance");
endmodule // interrupt_latch_enable_unit
`default_nettype wire

/* File: sim/cpu_model.sv */
// cpu core stand-in that takes offered requests after a set lag
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
  input  wire logic       clk_sys,
  input  wire logic [3:0] lag,      // extra cycles before accepting
  input  wire logic       irqReq,
  input  wire logic [3:0] irqSrc,
  input  wire logic       savedImf,
  output logic            accept,
  output logic      [3:0] takenSrc,
  output logic            pushed,   // stacked master flag
  output int              nAcc
);
  int cnt = 0;
  initial begin
    accept = 1'b0;
    nAcc = 0;
  end
  // stack flag and source at the taking edge, pulse lasts one cycle
  always @(posedge clk_sys) begin
    if (accept) begin
      takenSrc = irqSrc;
      pushed = savedImf;
      nAcc++;
    end
    #1;
    cnt = (irqReq && !accept) ? cnt + 1 : 0;
    accept = cnt > lag;
  end
endmodule // cpu_model
`default_nettype wire

/* File: sim/interrupt_latch_enable_unit_test.sv */
// self-checking bench for the latch and enable unit
`timescale 1ns/100ps
`default_nettype none
module interrupt_latch_enable_unit_test;
  logic        clk_sys, resetn, sfrWr, sfrRd, accept, retInstr, retImf;
  logic        eiInstr, diInstr, irqReq, savedImf, pushed;
  logic [15:0] srcReq;
  logic [7:0]  sfrAddr, sfrWdata, sfrRdata;
  logic [3:0]  irqSrc, takenSrc, lag;
  int          nAcc;
  int          mismatches = 0;
  int          n_checks = 0;
  interrupt_latch_enable_unit uut (.clk_sys(clk_sys), .resetn(resetn),
    .srcReq(srcReq), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrWdata(sfrWdata), .accept(accept), .retInstr(retInstr),
    .retImf(retImf), .eiInstr(eiInstr), .diInstr(diInstr),
    .sfrRdata(sfrRdata), .irqReq(irqReq), .irqSrc(irqSrc),
    .savedImf(savedImf));
  cpu_model cpu (.clk_sys(clk_sys), .lag(lag), .irqReq(irqReq),
    .irqSrc(irqSrc), .savedImf(savedImf), .accept(accept),
    .takenSrc(takenSrc), .pushed(pushed), .nAcc(nAcc));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse(ref logic s);
    tick;
    s = 1'b1;
    tick;
    s = 1'b0;
  endtask
  task automatic req(input logic [15:0] v);
    tick;
    srcReq = v;
    tick;
    srcReq = 16'h0000;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick;
    sfrAddr = a;
    sfrWdata = d;
    sfrWr = 1'b1;
    tick;
    sfrWr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    tick;
    sfrAddr = a;
    sfrRd = 1'b1;
    tick;
    sfrRd = 1'b0;
    chk(sfrRdata, exp);
  endtask
  // bounded wait for one more acceptance
  task automatic wait_acc(input int n0);
    for (int i = 0; i < 20 && nAcc == n0; i++) tick;
    chk(8'(nAcc - n0), 8'h01);
  endtask
  task automatic t_reset;
    rd(8'h3A, 8'h00);
    rd(8'h3B, 8'h00);
    rd(8'h3C, 8'h00);
    rd(8'h3D, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_latch;
    req(16'h8083);
    rd(8'h3C, 8'h80);
    rd(8'h3D, 8'h80);
    wr(8'h3C, 8'hFF);
    rd(8'h3C, 8'h80);
    wr(8'h3C, 8'h0C);
    rd(8'h3C, 8'h00);
    rd(8'h3D, 8'h80);
    wr(8'h3D, 8'h00);
    rd(8'h3D, 8'h00);
    $display("test latch done");
  endtask
  task automatic t_mask;
    int n;
    wr(8'h3A, 8'h0E);
    rd(8'h3A, 8'h00);
    req(16'h0200);
    wr(8'h3A, 8'h01);
    rd(8'h3A, 8'h01);
    chk({7'h00, irqReq}, 8'h00);
    pulse(diInstr);
    wr(8'h3B, 8'h02);
    rd(8'h3B, 8'h02);
    chk({7'h00, irqReq}, 8'h00);
    n = nAcc;
    pulse(eiInstr);
    wait_acc(n);
    chk({4'h0, takenSrc}, 8'h09);
    chk({7'h00, pushed}, 8'h01);
    rd(8'h3A, 8'h00);
    rd(8'h3D, 8'h00);
    retImf = pushed;
    pulse(retInstr);
    rd(8'h3A, 8'h01);
    pulse(diInstr);
    rd(8'h3A, 8'h00);
    $display("test mask done");
  endtask
  // slow cpu, both fixed sources at once, master flag off
  task automatic t_nmi;
    int n;
    lag = 4'h3;
    n = nAcc;
    req(16'h000C);
    wait_acc(n);
    chk({4'h0, takenSrc}, 8'h02);
    wait_acc(n + 1);
    chk({4'h0, takenSrc}, 8'h03);
    rd(8'h3C, 8'h00);
    $display("test nonmaskable done");
  endtask
  // second reset in mid run with state set, all back to zero
  task automatic t_rerun;
    req(16'h4000);
    wr(8'h3B, 8'h40);
    rd(8'h3D, 8'h40);
    tick;
    resetn = 1'b0;
    repeat (2) tick;
    resetn = 1'b1;
    rd(8'h3B, 8'h00);
    rd(8'h3D, 8'h00);
    rd(8'h3A, 8'h00);
    chk({7'h00, irqReq}, 8'h00);
    $display("test rerun done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {resetn, srcReq, sfrAddr, sfrWr, sfrRd, sfrWdata} = '0;
    {retInstr, retImf, eiInstr, diInstr, lag} = '0;
    repeat (16) @(posedge clk_sys);
    #1 resetn = 1'b1;
    t_reset;
    t_latch;
    t_mask;
    t_nmi;
    t_rerun;
    finish_test;
  end
  initial begin
    #200000;
    mismatches++;
    finish_test;
  end
endmodule // interrupt_latch_enable_unit_test
`default_nettype wire
